// ---- src/supply_supervisor_watchdog.sv ----
// supply supervisor with reset hold and kick watchdog
// assumes synchronous inputs; supply_low_in from an external comparator
`timescale 1ns/1ps

// Functional notes
// - steady kick for timeout gives an expiry pulse, then rearms and repeats
// - falling kick or reset release restarts timer
// - expiry is active-low open-drain, released otherwise
// - enable high runs watchdog, low disables it
// - reset held while supply low plus hold
// - startup delay begins at reset release
// - monitoring after startup only if enable high
// - kicks ignored in expiry, reset, startup, settle
// - enabled operation within 300 us settle
// - only kicks at least 1 us wide count
// - manual reset low holds reset, then hold
module supply_supervisor_watchdog
  import supervisor_pkg::*;
#(
  parameter int unsigned KICK_TIMEOUT       = KICK_TIMEOUT_TICKS,
  parameter int unsigned EXPIRY_PULSE_WIDTH = EXPIRY_PULSE_WIDTH_TICKS,
  parameter int unsigned STARTUP_DELAY      = STARTUP_DELAY_TICKS,
  parameter int unsigned RESET_HOLD_TIME    = RESET_HOLD_TIME_TICKS,
  parameter int unsigned ENABLE_SETTLE      = ENABLE_SETTLE_TICKS,
  parameter int unsigned TICK_PERIOD        = TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // supply and manual reset
  input  wire logic supply_low_in,
  input  wire logic manual_reset_in_n,
  // watchdog inputs
  input  wire logic kick_in,
  input  wire logic watchdog_enable_in,
  // open-drain reset output
  output logic      reset_out_n,
  output logic      reset_out_oe,
  // open-drain expiry output
  output logic      expiry_out_n,
  output logic      expiry_out_oe
);

  // ********************************
  // time base
  // ********************************
  tick_if tb ();

  tick_gen #(
    .TICKS_PER (TICK_PERIOD)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .tb    (tb)
  );

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic              rst_asserted;
    logic [TICK_W-1:0] hold_cnt;
    wd_state_t         wd;
    logic [TICK_W-1:0] wd_cnt;
    logic              kick_d;
    logic [KW_W-1:0]   kick_wide;
    logic              expiry;
  } sv_state_t;

  sv_state_t s_reg;
  sv_state_t s_next;

  logic reset_cause;
  logic kick_fall;
  logic kick_valid;

  always_comb begin
    reset_cause = supply_low_in || !manual_reset_in_n;
    kick_fall   = s_reg.kick_d && !kick_in;
    // pulse must have stood at least the least width before the fall
    kick_valid  = kick_fall &&
                  (s_reg.kick_wide >= KW_W'(KICK_MIN_CYCLES));
  end

  always_comb begin
    s_next        = s_reg;
    s_next.kick_d = kick_in;
    // width of the current kick level, saturating
    if (kick_in != s_reg.kick_d) begin
      s_next.kick_wide = KW_W'(1);
    end else if (s_reg.kick_wide != '1) begin
      s_next.kick_wide = s_reg.kick_wide + 1'b1;
    end

    // supply and manual reset with hold time
    if (reset_cause) begin
      s_next.rst_asserted = 1'b1;
      s_next.hold_cnt     = '0;
    end else if (s_reg.rst_asserted && tb.tick) begin
      if (s_reg.hold_cnt == TICK_W'(RESET_HOLD_TIME - 1)) begin
        s_next.rst_asserted = 1'b0;
        s_next.hold_cnt     = '0;
      end else begin
        s_next.hold_cnt = s_reg.hold_cnt + 1'b1;
      end
    end

    // watchdog
    case (s_reg.wd)
      WD_IDLE: begin
        s_next.expiry = 1'b0;
        s_next.wd_cnt = '0;
        if (s_reg.rst_asserted && !s_next.rst_asserted) begin
          s_next.wd = WD_STARTUP;
        end
      end
      WD_STARTUP: begin
        // kicks ignored here
        if (tb.tick) begin
          if (s_reg.wd_cnt == TICK_W'(STARTUP_DELAY - 1)) begin
            s_next.wd_cnt = '0;
            s_next.wd     = watchdog_enable_in ? WD_MONITOR
                                               : WD_SETTLE;
          end else begin
            s_next.wd_cnt = s_reg.wd_cnt + 1'b1;
          end
        end
      end
      WD_SETTLE: begin
        // disabled; on enable wait the settle time, kicks ignored
        if (!watchdog_enable_in) begin
          s_next.wd_cnt = '0;
        end else if (tb.tick) begin
          if (s_reg.wd_cnt == TICK_W'(ENABLE_SETTLE - 1)) begin
            s_next.wd_cnt = '0;
            s_next.wd     = WD_MONITOR;
          end else begin
            s_next.wd_cnt = s_reg.wd_cnt + 1'b1;
          end
        end
      end
      WD_MONITOR: begin
        if (!watchdog_enable_in) begin
          s_next.wd     = WD_SETTLE;
          s_next.wd_cnt = '0;
        end else if (kick_valid) begin
          s_next.wd_cnt = '0;
        end else if (tb.tick) begin
          if (s_reg.wd_cnt == TICK_W'(KICK_TIMEOUT - 1)) begin
            s_next.wd     = WD_EXPIRE;
            s_next.wd_cnt = '0;
            s_next.expiry = 1'b1;
          end else begin
            s_next.wd_cnt = s_reg.wd_cnt + 1'b1;
          end
        end
      end
      WD_EXPIRE: begin
        // kicks ignored while expiry is low
        if (tb.tick) begin
          if (s_reg.wd_cnt == TICK_W'(EXPIRY_PULSE_WIDTH - 1)) begin
            s_next.expiry = 1'b0;
            s_next.wd_cnt = '0;
            s_next.wd     = watchdog_enable_in ? WD_MONITOR : WD_SETTLE;
          end else begin
            s_next.wd_cnt = s_reg.wd_cnt + 1'b1;
          end
        end
      end
      default: begin
        s_next.wd = WD_IDLE;
      end
    endcase

    // reset overrides the watchdog entirely
    if (s_next.rst_asserted) begin
      s_next.wd     = WD_IDLE;
      s_next.wd_cnt = '0;
      s_next.expiry = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg              <= '0;
      s_reg.rst_asserted <= 1'b1;
      s_reg.kick_d       <= 1'b1;
      s_reg.wd           <= WD_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // open drain: only ever drive low
  assign reset_out_n   = 1'b0;
  assign reset_out_oe  = s_reg.rst_asserted;
  assign expiry_out_n  = 1'b0;
  assign expiry_out_oe = s_reg.expiry;

  // ********************************
  // checks
  // ********************************
  property p_reset_follows_cause;
    @(posedge clk) disable iff (reset)
      reset_cause |=> reset_out_oe;
  endproperty
  a_reset_follows_cause: assert property (p_reset_follows_cause)
    else $error("reset not asserted while a cause is present");

  property p_manual_reset;
    @(posedge clk) disable iff (reset)
      !manual_reset_in_n |=> reset_out_oe && !expiry_out_oe;
  endproperty
  a_manual_reset: assert property (p_manual_reset)
    else $error("manual reset did not assert reset");

  property p_release_starts;
    @(posedge clk) disable iff (reset)
      $fell(reset_out_oe) |-> s_reg.wd == WD_STARTUP && s_reg.wd_cnt == '0;
  endproperty
  a_release_starts: assert property (p_release_starts)
    else $error("startup delay not begun at reset release");

  property p_expiry_no_reset;
    @(posedge clk) disable iff (reset)
      expiry_out_oe |-> !reset_out_oe && s_reg.wd == WD_EXPIRE;
  endproperty
  a_expiry_no_reset: assert property (p_expiry_no_reset)
    else $error("expiry driven outside expire state");

  property p_expiry_entry;
    @(posedge clk) disable iff (reset)
      $rose(expiry_out_oe) |-> $past(s_reg.wd) == WD_MONITOR
        && $past(watchdog_enable_in);
  endproperty
  a_expiry_entry: assert property (p_expiry_entry)
    else $error("expiry began without enabled monitoring");

  property p_kick_clears;
    @(posedge clk) disable iff (reset)
      (s_reg.wd == WD_MONITOR && watchdog_enable_in && kick_valid
        && !reset_cause) |=> s_reg.wd_cnt == '0 && !expiry_out_oe;
  endproperty
  a_kick_clears: assert property (p_kick_clears)
    else $error("valid kick did not clear the timer");

  property p_disabled_quiet;
    @(posedge clk) disable iff (reset)
      (!watchdog_enable_in && s_reg.wd == WD_SETTLE && !reset_cause) |=>
        s_reg.wd == WD_SETTLE && s_reg.wd_cnt == '0 && !expiry_out_oe;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("expiry while watchdog disabled");

  // a narrow pulse must leave the running count alone
  property p_short_kick_ignored;
    @(posedge clk) disable iff (reset)
      (s_reg.wd == WD_MONITOR && watchdog_enable_in && !reset_cause
        && !tb.tick && kick_fall
        && s_reg.kick_wide < KW_W'(KICK_MIN_CYCLES))
        |=> s_reg.wd_cnt == $past(s_reg.wd_cnt);
  endproperty
  a_short_kick_ignored: assert property (p_short_kick_ignored)
    else $error("narrow kick was accepted");

  property p_settle_ignores_kick;
    @(posedge clk) disable iff (reset)
      (s_reg.wd == WD_SETTLE && watchdog_enable_in && !reset_cause
        && !tb.tick) |=> s_reg.wd == WD_SETTLE
        && s_reg.wd_cnt == $past(s_reg.wd_cnt);
  endproperty
  a_settle_ignores_kick: assert property (p_settle_ignores_kick)
    else $error("settle count moved without a tick");

endmodule

// ---- src/supervisor_pkg.sv ----
// constants and types shared by the supervisor and watchdog design
// assumes a 40 MHz clock and an internal time base derived from it
package supervisor_pkg;

  // ********************************
  // clock and time base
  // ********************************
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned TICK_NS         = 1_000;   // time base tick, 1 us
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;

  // ********************************
  // documented times
  // ********************************
  localparam int unsigned KICK_MIN_WIDTH_NS  = 1_000;   // least kick pulse
  localparam int unsigned ENABLE_SETTLE_US   = 300;     // longest settle
  // least time rounds up to whole cycles
  localparam int unsigned KICK_MIN_CYCLES =
    (KICK_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest time rounds down, counted in ticks
  localparam int unsigned ENABLE_SETTLE_TICKS =
    (ENABLE_SETTLE_US * 1_000) / TICK_NS;

  // ********************************
  // default timing in ticks (chosen option values)
  // ********************************
  localparam int unsigned KICK_TIMEOUT_TICKS       = 1_000_000; // 1 s
  localparam int unsigned EXPIRY_PULSE_WIDTH_TICKS = 200_000;   // 200 ms
  localparam int unsigned STARTUP_DELAY_TICKS      = 2_000_000; // 2 s
  localparam int unsigned RESET_HOLD_TIME_TICKS    = 200_000;   // 200 ms

  localparam int unsigned TICK_W = 24;
  localparam int unsigned PRE_W  = 8;
  localparam int unsigned KW_W   = 8;

  typedef enum logic [2:0] {
    WD_IDLE    = 3'b000,
    WD_STARTUP = 3'b001,
    WD_SETTLE  = 3'b011,
    WD_MONITOR = 3'b010,
    WD_EXPIRE  = 3'b110
  } wd_state_t;

endpackage

// ---- src/tick_if.sv ----
// time base strobe, shared between the counter modules
// assumes a single clock domain
`timescale 1ns/1ps
interface tick_if;
  logic tick;
  modport source (output tick);
  modport sink   (input  tick);
endinterface

// ---- src/tick_gen.sv ----
// internal time base: one-cycle strobe every TICKS_PER clock cycles
// assumes synchronous active-high reset
`timescale 1ns/1ps
module tick_gen
  import supervisor_pkg::*;
#(
  parameter int unsigned TICKS_PER = TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // strobe out
  tick_if.source    tb
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
    logic             tick;
  } tg_state_t;

  tg_state_t s_reg;
  tg_state_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == PRE_W'(TICKS_PER - 1)) begin
      s_next.cnt  = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tb.tick = s_reg.tick;

  // ********************************
  // checks
  // ********************************
  property p_tick_period;
    @(posedge clk) disable iff (reset)
      s_reg.tick |=> !s_reg.tick [*1];
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("time base strobe lasted more than one cycle");

endmodule

// ---- verification/host_kick_model.sv ----
// host side model: drives the kick line with a repeating high/low pattern
// assumes a single clock; pattern values are changed only between edges
`timescale 1ns/1ps
module host_kick_model (
  // clock
  input  wire logic       clk,
  // pattern control
  input  wire logic       run,
  input  wire logic [7:0] period,
  input  wire logic [7:0] high_len,
  // kick line
  output logic            kick_in
);
  // ********************************
  // pattern generator
  // ********************************
  logic [7:0] phase = 8'h00;

  // a stopped host leaves the line low, as a hung program would
  always @(posedge clk) begin
    if (run) begin
      phase   <= (phase + 8'h01 >= period) ? 8'h00 : phase + 8'h01;
      kick_in <= (phase < high_len);
    end else begin
      phase   <= 8'h00;
      kick_in <= 1'b0;
    end
  end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the supply supervisor and kick watchdog
// assumes shortened tick counts; durations allow tick phase slack
`timescale 1ns/1ps
module testbench;
  import supervisor_pkg::*;
  // ********************************
  // shortened timing, in ticks; TP is the tick period in clock cycles
  // ********************************
  localparam int TP = 4;
  localparam int TO = 20;
  localparam int EXW = 5;
  localparam int SU = 30;
  localparam int HOLD = 10;
  localparam int SET = 4;

  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       supply_low_in = 1'b0;
  logic       manual_reset_in_n = 1'b1;
  logic       watchdog_enable_in = 1'b1;
  logic       run = 1'b1;
  logic [7:0] period = 8'h32;
  logic [7:0] high_len = 8'h2C;
  logic       kick_in, kick_d;
  logic       reset_out_n, reset_out_oe, expiry_out_n, expiry_out_oe;
  int         fails = 0, num_checks = 0, cyc = 0, hi_len = 0, n;
  int         falls[$];

  supply_supervisor_watchdog #(
    .KICK_TIMEOUT(TO), .EXPIRY_PULSE_WIDTH(EXW), .STARTUP_DELAY(SU),
    .RESET_HOLD_TIME(HOLD), .ENABLE_SETTLE(SET), .TICK_PERIOD(TP)
  ) i_supply_supervisor_watchdog (
    .clk(clk), .reset(reset), .supply_low_in(supply_low_in),
    .manual_reset_in_n(manual_reset_in_n), .kick_in(kick_in),
    .watchdog_enable_in(watchdog_enable_in), .reset_out_n(reset_out_n),
    .reset_out_oe(reset_out_oe), .expiry_out_n(expiry_out_n),
    .expiry_out_oe(expiry_out_oe)
  );

  host_kick_model i_host_kick_model (
    .clk(clk), .run(run), .period(period), .high_len(high_len),
    .kick_in(kick_in)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // reference timeline: cycle count and the valid host falling edges
  always @(posedge clk) begin
    cyc    <= cyc + 1;
    kick_d <= kick_in;
    hi_len <= (kick_in === 1'b1) ? hi_len + 1 : 0;
    // a fall counts only after a high level of the least kick width
    if (kick_d && !kick_in && hi_len >= KICK_MIN_CYCLES) begin
      falls.push_back(cyc);
    end
  end

  // ********************************
  // shared tasks
  // ********************************
  task automatic check(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  // tick phase can add up to a tick or two of slack
  function automatic logic in_win(input int seen, input int ticks);
    return seen >= ticks * TP - 4 && seen <= (ticks + 2) * TP + 4;
  endfunction

  task automatic wait_for(input int sel, input logic v, input int lim,
                          output int k);
    k = 0;
    while (k < lim &&
           ((sel == 0) ? reset_out_oe : expiry_out_oe) !== v) begin
      @(posedge clk) #1;
      k++;
    end
  endtask

  task automatic count_high(input int cycles, output int hits);
    hits = 0;
    repeat (cycles) begin
      @(posedge clk) #1;
      if (expiry_out_oe !== 1'b0) hits++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // ********************************
  // test sequence
  // ********************************
  initial begin
    void'($urandom(92));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk) #1;
    check("reset_oe", reset_out_oe, 1'b1);
    check("expiry_oe", expiry_out_oe, 1'b0);
    check("reset_n", reset_out_n, 1'b0);
    check("expiry_n", expiry_out_n, 1'b0);
    wait_for(0, 1'b0, 200, n);
    check("hold", in_win(n + 1, HOLD), 1'b1);
    @(posedge clk) period <= 8'(45 + $urandom % 20);
    count_high(600, n);
    check("kicked", n, 0);
    $display("test steady_kicks done");

    @(posedge clk);
    while (kick_in !== 1'b0) @(posedge clk);
    run <= 1'b0;
    wait_for(1, 1'b1, 300, n);
    check("timeout", in_win(cyc - falls[$], TO), 1'b1);
    wait_for(1, 1'b0, 100, n);
    check("pulse", in_win(n, EXW), 1'b1);
    wait_for(1, 1'b1, 300, n);
    check("rearm", in_win(n, TO), 1'b1);
    $display("test missed_kick done");

    wait_for(1, 1'b0, 100, n);
    @(posedge clk);
    high_len <= 8'(10 + $urandom % 25);
    period   <= 8'h28;
    run      <= 1'b1;
    wait_for(1, 1'b1, 300, n);
    check("short_kick", n <= (TO + 2) * TP + 4, 1'b1);
    $display("test short_kick done");

    wait_for(1, 1'b0, 100, n);
    @(posedge clk);
    run <= 1'b0;
    watchdog_enable_in <= 1'b0;
    count_high(400, n);
    check("disabled", n, 0);
    @(posedge clk) watchdog_enable_in <= 1'b1;
    wait_for(1, 1'b1, 300, n);
    check("settle", in_win(n, SET + TO), 1'b1);
    $display("test enable done");

    for (int c = 0; c < 2; c++) begin
      wait_for(1, 1'b0, 100, n);
      @(posedge clk);
      high_len <= 8'h2C;
      period   <= 8'h32;
      run      <= 1'b1;
      repeat (100) @(posedge clk);
      if (c == 0) supply_low_in <= 1'b1;
      else manual_reset_in_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("cause_oe", reset_out_oe, 1'b1);
      count_high(8'(30 + $urandom % 40), n);
      check("no_exp_rst", n, 0);
      @(posedge clk);
      supply_low_in      <= 1'b0;
      manual_reset_in_n  <= 1'b1;
      run                <= 1'b0;
      watchdog_enable_in <= (c == 0);
      wait_for(0, 1'b0, 200, n);
      check("cause_hold", in_win(n, HOLD), 1'b1);
      if (c == 1) begin
        // enable low at startup end parks the watchdog until it rises
        count_high(SU * TP + 100, n);
        check("startup_off", n, 0);
        @(posedge clk) watchdog_enable_in <= 1'b1;
        wait_for(1, 1'b1, 400, n);
        check("startup_settle", in_win(n, SET + TO), 1'b1);
      end else begin
        wait_for(1, 1'b1, 400, n);
        check("startup", in_win(n, SU + TO), 1'b1);
      end
      $display("test reset_cause %0d done", c);
    end
    report_and_stop();
  end
endmodule
